// File: rtl/tla_pkg.sv
// constants, state types and reset values for the temperature limit alert
// What this block does
// - alert offers two behaviours, comparator mode and latched interrupt mode.
// - after reset the mode setting selects latched interrupt mode.
// - alert goes active when temperature is above upper or below lower limit.
// - comparator mode releases alert once back inside limits by hysteresis.
// - comparator mode keeps alert state unchanged when shutdown is entered.
// - interrupt mode clears alert on any register read.
// - interrupt mode re-asserts only on a new result outside the limits.
// - interrupt mode clears alert when shutdown is entered.
package tla_pkg;

    // ==========================================================
    // register map, byte addresses
    localparam logic [4:0] ADDR_CFG  = 5'h00;
    localparam logic [4:0] ADDR_HIGH = 5'h04;
    localparam logic [4:0] ADDR_LOW  = 5'h08;
    localparam logic [4:0] ADDR_HYST = 5'h0c;
    localparam logic [4:0] ADDR_TEMP = 5'h10;
    localparam logic [4:0] ADDR_STAT = 5'h14;

    // ==========================================================
    // field positions
    localparam int CFG_MODE_BIT   = 0;
    localparam int CFG_POL_BIT    = 1;
    localparam int CFG_SD_BIT     = 2;
    localparam int STAT_ALERT_BIT = 0;
    localparam int STAT_OVER_BIT  = 1;
    localparam int STAT_UNDER_BIT = 2;

    // ==========================================================
    // values after reset
    localparam logic        CMP_MODE_RST = 1'b0;
    localparam logic        POL_HIGH_RST = 1'b0;
    localparam logic        SHUTDOWN_RST = 1'b0;
    localparam logic [15:0] HIGH_RST     = 16'h2000;
    localparam logic [15:0] LOW_RST      = 16'h0500;
    localparam logic [15:0] HYST_RST     = 16'h0280;

    // ==========================================================
    // state of the alert core
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        cmp_mode;
        logic        pol_high;
        logic        shutdown;
        logic [15:0] t_high;
        logic [15:0] t_low;
        logic [15:0] temp_hysteresis;
        logic [15:0] temp;
        logic        over;
        logic        under;
        logic        alert;
    } tla_state_type;

    localparam tla_state_type ST_RST = '{
        waitreq:         1'b1,
        cmp_mode:        CMP_MODE_RST,
        pol_high:        POL_HIGH_RST,
        shutdown:        SHUTDOWN_RST,
        t_high:          HIGH_RST,
        t_low:           LOW_RST,
        temp_hysteresis: HYST_RST,
        default:         '0
    };

    // state of the open-drain driver
    typedef struct packed {
        logic oe;
        logic out;
    } tla_pin_type;

endpackage : tla_pkg

// File: rtl/tla_cmp.sv
// signed limit and hysteresis comparisons for one result
`timescale 1ns/1ns
`default_nettype none
module tla_cmp (
    // operands
    input  wire logic [15:0] temp_i,
    input  wire logic [15:0] high_i,
    input  wire logic [15:0] low_i,
    input  wire logic [15:0] hyst_i,
    // results
    output logic             above_high_o,
    output logic             below_low_o,
    output logic             below_high_hyst_o,
    output logic             above_low_hyst_o
);
    // 18 bits: signed limit plus or minus a full unsigned hysteresis
    // still fits, so extreme settings cannot wrap
    logic signed [17:0] temp_s;
    logic signed [17:0] high_s;
    logic signed [17:0] low_s;
    logic signed [17:0] hyst_s;
    logic signed [17:0] high_rel;
    logic signed [17:0] low_rel;

    assign temp_s   = {{2{temp_i[15]}}, temp_i};
    assign high_s   = {{2{high_i[15]}}, high_i};
    assign low_s    = {{2{low_i[15]}}, low_i};
    assign hyst_s   = {2'b00, hyst_i};
    assign high_rel = high_s - hyst_s;
    assign low_rel  = low_s + hyst_s;

    assign above_high_o      = temp_s > high_s;
    assign below_low_o       = temp_s < low_s;
    assign below_high_hyst_o = temp_s < high_rel;
    assign above_low_hyst_o  = temp_s > low_rel;
endmodule : tla_cmp
`default_nettype wire

// File: rtl/tla_od_pin.sv
// open-drain alert pin driver with polarity select
`timescale 1ns/1ns
`default_nettype none
module tla_od_pin (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    // alert state
    input  wire logic active_i,
    input  wire logic pol_high_i,
    // pin
    output logic      pin_o,
    output logic      pin_oe_o
);
    tla_pkg::tla_pin_type st_q;
    tla_pkg::tla_pin_type st_d;

    always_comb begin
        st_d     = st_q;
        // active-low pulls when active, active-high pulls when idle
        st_d.oe  = active_i ^ pol_high_i;
        st_d.out = 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_o    = st_q.out;
    assign pin_oe_o = st_q.oe;
endmodule : tla_od_pin
`default_nettype wire

// File: rtl/tla_alert.sv
// temperature limit alert core with avalon-mm register slave
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tla_alert (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // conversion results
    input  wire logic [15:0] temp_result_i,
    input  wire logic        temp_valid_i,
    // converter control
    output logic             shutdown_o,
    // open-drain alert pin
    output logic             alert_pin_o,
    output logic             alert_pin_oe_o
);

    // ==========================================================
    // helpers
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            r[15:8] = wdata[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic [31:0] read_word(
        input logic [4:0]          addr,
        input tla_pkg::tla_state_type s
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (addr)
            tla_pkg::ADDR_CFG: begin
                r[tla_pkg::CFG_MODE_BIT] = s.cmp_mode;
                r[tla_pkg::CFG_POL_BIT]  = s.pol_high;
                r[tla_pkg::CFG_SD_BIT]   = s.shutdown;
            end
            tla_pkg::ADDR_HIGH: r[15:0] = s.t_high;
            tla_pkg::ADDR_LOW:  r[15:0] = s.t_low;
            tla_pkg::ADDR_HYST: r[15:0] = s.temp_hysteresis;
            tla_pkg::ADDR_TEMP: r[15:0] = s.temp;
            tla_pkg::ADDR_STAT: begin
                r[tla_pkg::STAT_ALERT_BIT] = s.alert;
                r[tla_pkg::STAT_OVER_BIT]  = s.over;
                r[tla_pkg::STAT_UNDER_BIT] = s.under;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // ==========================================================
    // state and decode
    tla_pkg::tla_state_type st_q;
    tla_pkg::tla_state_type st_d;

    logic rd_done;
    logic wr_done;
    logic cfg_wr;
    logic sd_entry;
    logic new_res;
    logic above_high;
    logic below_low;
    logic below_hh;
    logic above_lh;
    logic hit;

    // an access completes at the edge where waitrequest is seen low
    assign rd_done  = avs_read_i & ~st_q.waitreq;
    assign wr_done  = avs_write_i & ~st_q.waitreq;
    assign cfg_wr   = wr_done & (avs_address_i == tla_pkg::ADDR_CFG)
                      & avs_byteenable_i[0];
    assign sd_entry = cfg_wr & avs_writedata_i[tla_pkg::CFG_SD_BIT]
                      & ~st_q.shutdown;
    // no conversions while shut down, so results then are ignored
    assign new_res  = temp_valid_i & ~st_q.shutdown;
    assign hit      = above_high | below_low;

    tla_cmp u_cmp (
        .temp_i            (temp_result_i),
        .high_i            (st_q.t_high),
        .low_i             (st_q.t_low),
        .hyst_i            (st_q.temp_hysteresis),
        .above_high_o      (above_high),
        .below_low_o       (below_low),
        .below_high_hyst_o (below_hh),
        .above_low_hyst_o  (above_lh)
    );

    // ==========================================================
    // next state
    always_comb begin
        st_d         = st_q;
        st_d.waitreq = 1'b1;

        // one wait state, then the answer for exactly one cycle
        if ((avs_read_i | avs_write_i) & st_q.waitreq) begin
            st_d.waitreq = 1'b0;
            if (avs_read_i) begin
                st_d.rdata = read_word(avs_address_i, st_q);
            end
        end

        if (wr_done) begin
            case (avs_address_i)
                tla_pkg::ADDR_CFG: begin
                    if (avs_byteenable_i[0]) begin
                        st_d.cmp_mode =
                            avs_writedata_i[tla_pkg::CFG_MODE_BIT];
                        st_d.pol_high =
                            avs_writedata_i[tla_pkg::CFG_POL_BIT];
                        st_d.shutdown =
                            avs_writedata_i[tla_pkg::CFG_SD_BIT];
                    end
                end
                tla_pkg::ADDR_HIGH: begin
                    st_d.t_high = merge16(st_q.t_high, avs_writedata_i,
                                          avs_byteenable_i);
                end
                tla_pkg::ADDR_LOW: begin
                    st_d.t_low = merge16(st_q.t_low, avs_writedata_i,
                                         avs_byteenable_i);
                end
                tla_pkg::ADDR_HYST: begin
                    st_d.temp_hysteresis =
                        merge16(st_q.temp_hysteresis, avs_writedata_i,
                                avs_byteenable_i);
                end
                // result and status are read-only
                default: st_d.temp = st_q.temp;
            endcase
        end

        // hysteresis tracking runs in both modes so a mode change
        // starts from a consistent over/under picture
        if (new_res) begin
            st_d.temp  = temp_result_i;
            st_d.over  = st_q.over ? ~below_hh : above_high;
            st_d.under = st_q.under ? ~above_lh : below_low;
        end

        if (st_q.cmp_mode) begin
            // shutdown is deliberately not looked at here
            if (new_res) begin
                st_d.alert = st_d.over | st_d.under;
            end
        end else begin
            if (rd_done | sd_entry) begin
                st_d.alert = 1'b0;
            end
            // a fresh excursion wins over a clear in the same cycle
            if (new_res & hit) begin
                st_d.alert = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q <= tla_pkg::ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // pin driver
    tla_od_pin u_pin (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .active_i   (st_q.alert),
        .pol_high_i (st_q.pol_high),
        .pin_o      (alert_pin_o),
        .pin_oe_o   (alert_pin_oe_o)
    );

    assign avs_readdata_o    = st_q.rdata;
    assign avs_waitrequest_o = st_q.waitreq;
    assign shutdown_o        = st_q.shutdown;

    // ==========================================================
    // assertions
    sequence s_int_excursion;
        !st_q.cmp_mode && new_res && hit;
    endsequence

    sequence s_int_clear;
        !st_q.cmp_mode && !new_res;
    endsequence

    property p_mode_reset;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !$past(rst_b_i) |-> (!st_q.cmp_mode && !st_q.alert);
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("mode not interrupt after reset");

    property p_int_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_int_excursion |=> st_q.alert ##1 alert_pin_oe_o != st_q.pol_high;
    endproperty
    a_int_set: assert property (p_int_set)
        else $error("excursion did not raise alert");

    property p_cmp_follow;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_q.cmp_mode && new_res |=> st_q.alert == (st_q.over | st_q.under);
    endproperty
    a_cmp_follow: assert property (p_cmp_follow)
        else $error("comparator alert differs from limit flags");

    property p_cmp_release;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_q.cmp_mode && new_res && st_q.over && !st_q.under && below_hh
            && !below_low |=> !st_q.alert;
    endproperty
    a_cmp_release: assert property (p_cmp_release)
        else $error("comparator alert not released below hysteresis");

    property p_cmp_sd_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_q.cmp_mode && sd_entry && !new_res |=> $stable(st_q.alert);
    endproperty
    a_cmp_sd_hold: assert property (p_cmp_sd_hold)
        else $error("shutdown changed comparator alert");

    property p_int_read_clr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_int_clear ##0 rd_done |=> !st_q.alert;
    endproperty
    a_int_read_clr: assert property (p_int_read_clr)
        else $error("register read did not clear alert");

    property p_int_no_spurious;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !st_q.cmp_mode && !st_q.alert && !(new_res && hit)
            |=> !st_q.alert;
    endproperty
    a_int_no_spurious: assert property (p_int_no_spurious)
        else $error("alert rose without excursion");

    property p_int_sd_clr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_int_clear ##0 sd_entry |=> !st_q.alert ##1 shutdown_o;
    endproperty
    a_int_sd_clr: assert property (p_int_sd_clr)
        else $error("shutdown did not clear alert");

    property p_pin_level;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |->
            alert_pin_oe_o == ($past(st_q.alert) ^ $past(st_q.pol_high))
            && !alert_pin_o;
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin drive does not match alert and polarity");

    property p_update_only_on_result;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !new_res && !rd_done && !sd_entry
            |=> $stable(st_q.alert) && $stable(st_q.temp);
    endproperty
    a_update_only_on_result: assert property (p_update_only_on_result)
        else $error("alert changed without a new result");

    property p_bus_answer;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (avs_read_i || avs_write_i) && st_q.waitreq
            |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest did not drop for one cycle");

endmodule : tla_alert
`default_nettype wire

// File: verif/tla_host_model.sv
// host side of the alert line: pull-up resistor and interrupt input
`timescale 1ns/1ns
`default_nettype none
module tla_host_model (
    // device pin
    input  wire logic pin_i,
    input  wire logic pin_oe_i,
    // level seen by the host
    output logic      line_o
);
    // ==========================================================
    // wire resolution
    // released line floats to the pull-up, never to the last driven value
    assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule : tla_host_model
`default_nettype wire

// File: verif/tla_alert_test.sv
// self-checking bench for the temperature limit alert
`timescale 1ns/1ns
`default_nettype none
module tla_alert_test;
    logic        ref_clk_i;
    logic        rst_b_i;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic [15:0] temp;
    logic        valid;
    logic        sd;
    logic        pin;
    logic        pin_oe;
    logic        line;
    int          n_mismatch;
    int          check_count;

    tla_alert DUT (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'h3),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .temp_result_i(temp), .temp_valid_i(valid), .shutdown_o(sd),
        .alert_pin_o(pin), .alert_pin_oe_o(pin_oe)
    );
    tla_host_model host (.pin_i(pin), .pin_oe_i(pin_oe), .line_o(line));

    // ==========================================================
    // tasks
    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // request stands until the rising edge at which waitrequest is low;
    // only the watchdog ends a wait that never gets its answer
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        @(posedge ref_clk_i);
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("bus wait states", n, 32'h2);
    endtask : bus

    task rd_reg(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("read data", q, exp);
    endtask : rd_reg

    task wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr_reg

    task settle;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask : settle

    task result(input logic [15:0] t);
        @(posedge ref_clk_i);
        temp  <= t;
        valid <= 1'b1;
        @(posedge ref_clk_i);
        valid <= 1'b0;
        settle();
    endtask : result

    task line_is(input logic exp);
        chk("alert line", {31'h0, line}, {31'h0, exp});
    endtask : line_is

    task results;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // ==========================================================
    // clock, watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_mismatch++;
        results();
    end

    // ==========================================================
    // tests
    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst_b_i = 1'b0;
        addr = 5'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        temp = 16'h0000;
        valid = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        // interrupt mode, active low
        rd_reg(tla_pkg::ADDR_CFG, 32'h0);
        line_is(1'b1);
        rd_reg(tla_pkg::ADDR_HIGH, 32'h2000);
        result(16'h2000);
        line_is(1'b1);
        result(16'h2001);
        line_is(1'b0);
        result(16'h1000);
        line_is(1'b0);
        rd_reg(5'h18, 32'h0);
        settle();
        line_is(1'b1);
        result(16'h1000);
        line_is(1'b1);
        result(16'h04ff);
        line_is(1'b0);
        wr_reg(tla_pkg::ADDR_CFG, 32'h4);
        settle();
        line_is(1'b1);
        chk("shutdown", {31'h0, sd}, 32'h1);
        result(16'h3000);
        line_is(1'b1);
        rd_reg(tla_pkg::ADDR_TEMP, 32'h04ff);
        // comparator mode with hysteresis
        wr_reg(tla_pkg::ADDR_CFG, 32'h1);
        result(16'h2001);
        line_is(1'b0);
        result(16'h1e00);
        line_is(1'b0);
        rd_reg(tla_pkg::ADDR_STAT, 32'h3);
        settle();
        line_is(1'b0);
        wr_reg(tla_pkg::ADDR_CFG, 32'h5);
        settle();
        line_is(1'b0);
        wr_reg(tla_pkg::ADDR_CFG, 32'h1);
        result(16'h1d7f);
        line_is(1'b1);
        result(16'h04ff);
        line_is(1'b0);
        result(16'h0700);
        line_is(1'b0);
        result(16'h0781);
        line_is(1'b1);
        // a changed result without its strobe must be ignored
        @(posedge ref_clk_i);
        temp <= 16'h7000;
        settle();
        line_is(1'b1);
        // active-high polarity in both modes
        wr_reg(tla_pkg::ADDR_CFG, 32'h3);
        settle();
        line_is(1'b0);
        result(16'h2001);
        line_is(1'b1);
        wr_reg(tla_pkg::ADDR_CFG, 32'h2);
        settle();
        line_is(1'b1);
        rd_reg(tla_pkg::ADDR_HYST, 32'h0280);
        settle();
        line_is(1'b0);
        results();
    end
endmodule : tla_alert_test
`default_nettype wire
